// file: src/lvic_top.sv
// supply monitor control: status flag, undervoltage reset and apb registers
// Contract
// R1 - monitor is enabled straight out of reset without software setup
// R2 - monitoring runs only while power disable bit is zero
// R3 - with reset disable zero, falling below falling level asserts system reset
// R4 - in stop mode monitor runs only if stop enable set; low supply resets
// R5 - trip select one picks 5 V levels, zero picks 3 V levels
// R6 - power-on reset returns trip select to 3 V
// R7 - selecting 5 V while below its rising level resets at once and holds
// R8 - reset held until rising indication shows supply above rising level
// R9 - undervoltage reset also drives external active-low reset pin low
// R10 - flag is 1 below falling level, 0 above rising, else holds
// R11 - any reset clears flag; flag is read only
// R12 - polled use: power disable 0, reset disable 1, flag only
// R13 - no interrupt request; outputs are flag and reset request
// R14 - monitor stays active in wait mode and its reset ends wait
// R15 - control bits come from system config register, not status register
// R16 - comparator indications pass a two-stage synchroniser first
`timescale 1ns/1ps
`default_nettype none
`include "lvic_defines.svh"
module lvic_top
  import lvic_pkg::*;
(
  // clock and resets
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        por_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // comparator, per level set (bit0 = 3 V set, bit1 = 5 V set)
  input  wire logic [1:0]  below_falling,
  input  wire logic [1:0]  above_rising,
  // system mode
  input  wire logic        stop_mode,
  input  wire logic        wait_mode,
  // reset outputs and trip level select
  output logic             uv_reset_req,
  output logic             rst_pin_o,
  output logic             rst_pin_oe,
  output logic             trip_level_select
);
  // ---- synchronised comparator levels
  logic [3:0] cmp_s;
  // cleared by power-on reset only, so the hold sees the rise while system reset is low
  lvic_sync #(.W(4)) u_sync (  // R16
    .clk      (clk),
    .arst_n   (por_n),
    .async_in ({above_rising, below_falling}),
    .sync_out (cmp_s)
  );

  // select the level set by trip select
  function automatic logic pick(input logic [1:0] v, input logic sel);
    pick = sel ? v[1] : v[0];
  endfunction

  // address decode shared by the write, read and error paths
  function automatic logic is_status(input logic [11:0] a);
    is_status = (a == `LVIC_STATUS_OFS);
  endfunction
  function automatic logic is_config(input logic [11:0] a);
    is_config = (a == `LVIC_CONFIG_OFS);
  endfunction

  logic below_f;
  logic above_r;

  // ---- config register: pwrd, rstd, stop; trip select reset by por only
  logic [2:0] cfg_q;
  logic [2:0] cfg_d;
  logic       trip_q;
  logic       trip_d;
  logic       flag_q;
  logic       flag_d;
  logic       wr_en;
  logic       rd_en;
  logic       monitor_on;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;

  always_comb begin
    cfg_d  = cfg_q;
    trip_d = trip_q;
    if (wr_en && is_config(paddr)) begin  // R15
      cfg_d[0] = pwdata[`LVIC_CFG_PWRD_BIT];
      cfg_d[1] = pwdata[`LVIC_CFG_RSTD_BIT];
      cfg_d[2] = pwdata[`LVIC_CFG_STOP_BIT];
      trip_d   = pwdata[`LVIC_CFG_TRIP_BIT];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= 3'(`LVIC_CFG_RESET);  // R1
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // trip select survives system reset; only power-on reset restores 3 V
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      trip_q <= `LVIC_TRIP_RESET;  // R6
    end else begin
      trip_q <= trip_d;
    end
  end

  assign trip_level_select = trip_q;
  assign below_f = pick(cmp_s[1:0], trip_q);  // R5
  assign above_r = pick(cmp_s[3:2], trip_q);  // R5

  // monitor active unless power disabled, or in stop without enable
  assign monitor_on = ~cfg_q[0] & (~stop_mode | cfg_q[2]);  // R2 R4 R14

  // ---- status flag with hysteresis
  always_comb begin
    flag_d = flag_q;
    if (monitor_on) begin
      if (below_f) begin
        flag_d = 1'b1;  // R10
      end else if (above_r) begin
        flag_d = 1'b0;  // R10
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_q <= 1'b0;  // R11
    end else begin
      flag_q <= flag_d;
    end
  end

  // ---- undervoltage reset sequencer
  lvic_state_t st_q;
  lvic_state_t st_d;
  logic        trip5_rise;
  logic        trip_prev_q;

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      trip_prev_q <= 1'b0;
    end else begin
      trip_prev_q <= trip_q;
    end
  end
  assign trip5_rise = trip_q & ~trip_prev_q;

  always_comb begin
    st_d = st_q;
    case (st_q)
      LVIC_IDLE: begin
        if (!monitor_on) begin
          st_d = LVIC_OFF;
        end else if (!cfg_q[1] && (below_f || (trip5_rise && !above_r))) begin
          st_d = LVIC_HOLD;  // R3 R7
        end
      end
      LVIC_HOLD: begin
        if (above_r) begin
          st_d = LVIC_IDLE;  // R8
        end
      end
      LVIC_OFF: begin
        if (monitor_on) begin
          st_d = LVIC_IDLE;
        end
      end
      default: st_d = LVIC_IDLE;
    endcase
  end

  // hold state must survive the reset it raises, so it clears on por only
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      st_q <= LVIC_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // reset request is the only event output; it also ends wait/stop
  assign uv_reset_req = (st_q == LVIC_HOLD);  // R13 R14
  assign rst_pin_o    = 1'b0;
  assign rst_pin_oe   = uv_reset_req;  // R9

  // ---- apb read and answer
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  always_comb begin
    rdata_d = rdata_q;
    if (rd_en) begin
      if (is_status(paddr)) begin
        rdata_d = {24'h0, flag_q, 7'h0};  // R11
      end else if (is_config(paddr)) begin
        rdata_d = {28'h0, trip_q, cfg_q[2], cfg_q[1], cfg_q[0]};
      end else begin
        rdata_d = 32'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // data comes combinationally in the access cycle from flops
  assign prdata  = rd_en ? rdata_d : rdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~is_status(paddr) & ~is_config(paddr);

  // ---- assertions
  a_flag_sets_low: assert property (@(posedge clk) disable iff (!arst_n) // R10
    (monitor_on && below_f) |=> flag_q)
    else $error("flag not set below falling level");

  a_flag_clears_high: assert property (@(posedge clk) disable iff (!arst_n) // R10
    (monitor_on && !below_f && above_r) |=> !flag_q)
    else $error("flag not cleared above rising level");

  a_flag_holds_mid: assert property (@(posedge clk) disable iff (!arst_n) // R10
    (!below_f && !above_r) |=> $stable(flag_q))
    else $error("flag changed between levels");

  a_flag_off_hold: assert property (@(posedge clk) disable iff (!arst_n) // R2
    (!monitor_on) |=> $stable(flag_q))
    else $error("flag changed while monitoring is off");

  a_polled_flag: assert property (@(posedge clk) disable iff (!arst_n) // R12
    (cfg_q[1] && monitor_on && below_f) |=> flag_q)
    else $error("flag not set in polled use");

  a_reset_on_low: assert property (@(posedge clk) disable iff (!por_n) // R3
    (st_q == LVIC_IDLE && monitor_on && !cfg_q[1] && below_f) |=> uv_reset_req)
    else $error("no reset on low supply");

  a_trip5_entry: assert property (@(posedge clk) disable iff (!por_n) // R7
    (st_q == LVIC_IDLE && monitor_on && !cfg_q[1] && trip5_rise && !above_r)
    |=> uv_reset_req)
    else $error("no reset after selecting 5 V below its rising level");

  a_no_reset_polled: assert property (@(posedge clk) disable iff (!por_n) // R12
    (st_q == LVIC_IDLE && cfg_q[1]) |=> !uv_reset_req)
    else $error("reset raised while resets disabled");

  a_hold_until_rise: assert property (@(posedge clk) disable iff (!por_n) // R8
    (uv_reset_req && !above_r) |=> uv_reset_req)
    else $error("reset released before rising level");

  a_release_high: assert property (@(posedge clk) disable iff (!por_n) // R8
    (uv_reset_req && above_r) |=> !uv_reset_req)
    else $error("reset kept above rising level");

  a_pin_follows: assert property (@(posedge clk) disable iff (!por_n) // R9
    rst_pin_oe == uv_reset_req && !rst_pin_o)
    else $error("reset pin not driven low");

  a_off_no_reset: assert property (@(posedge clk) disable iff (!por_n) // R2
    (st_q == LVIC_IDLE && cfg_q[0]) |=> !uv_reset_req)
    else $error("reset raised while powered down");

  a_stop_gate: assert property (@(posedge clk) disable iff (!arst_n) // R4
    (stop_mode && !cfg_q[2]) |-> !monitor_on)
    else $error("monitor active in stop without stop enable");

  a_wait_active: assert property (@(posedge clk) disable iff (!arst_n) // R14
    (wait_mode && !stop_mode && !cfg_q[0]) |-> monitor_on)
    else $error("monitor inactive in wait mode");

  a_trip_write_only: assert property (@(posedge clk) disable iff (!por_n) // R6
    !(wr_en && is_config(paddr)) |=> $stable(trip_q))
    else $error("trip select changed without a config write");

  a_cfg_not_status: assert property (@(posedge clk) disable iff (!arst_n) // R15
    (wr_en && is_status(paddr)) |=> $stable(cfg_q))
    else $error("control bits changed by a status write");

  a_status_ro: assert property (@(posedge clk) disable iff (!arst_n) // R11
    (wr_en && is_status(paddr) && !below_f && !above_r) |=> $stable(flag_q))
    else $error("status flag written by software");

  c_reset_entry: cover property (@(posedge clk) disable iff (!por_n)
    $rose(uv_reset_req));

  c_reset_exit: cover property (@(posedge clk) disable iff (!por_n)
    $fell(uv_reset_req));

  c_trip5_entry: cover property (@(posedge clk) disable iff (!por_n)
    trip5_rise && !above_r && !cfg_q[1]);

  c_stop_reset: cover property (@(posedge clk) disable iff (!por_n)
    stop_mode && $rose(uv_reset_req));

  c_mid_hold: cover property (@(posedge clk) disable iff (!arst_n)
    flag_q && !below_f && !above_r);
endmodule // lvic_top
`default_nettype wire

// file: src/lvic_defines.svh
// register offsets, field positions and reset values of the supply monitor
`ifndef LVIC_DEFINES_SVH
`define LVIC_DEFINES_SVH
`define LVIC_STATUS_OFS      12'h000
`define LVIC_CONFIG_OFS      12'h004
`define LVIC_FLAG_BIT        7
`define LVIC_CFG_PWRD_BIT    0
`define LVIC_CFG_RSTD_BIT    1
`define LVIC_CFG_STOP_BIT    2
`define LVIC_CFG_TRIP_BIT    3
`define LVIC_CFG_WIDTH       4
`define LVIC_CFG_RESET       4'h0
`define LVIC_TRIP_RESET      1'b0
`endif

// file: src/lvic_pkg.sv
// types shared by the supply monitor files
`default_nettype none
package lvic_pkg;
  typedef enum logic [2:0] {
    LVIC_IDLE = 3'b001,
    LVIC_HOLD = 3'b010,
    LVIC_OFF  = 3'b100
  } lvic_state_t;
endpackage
`default_nettype wire

// file: src/lvic_sync.sv
// two-stage synchroniser for comparator levels
`timescale 1ns/1ps
`default_nettype none
module lvic_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
    end
  end
  assign sync_out = s2_q;
endmodule // lvic_sync
`default_nettype wire

// file: tb/lvic_supply_model.sv
// analog supply comparator model for both trip level sets
`timescale 1ns/1ps
`default_nettype none
module lvic_supply_model (
  // supply band: 0 under 3 v fall, 1 in 3 v band, 2 over 3 v rise, 3 in 5 v band, 4 over 5 v rise
  input  wire logic [2:0] lvl,
  // comparator levels, bit0 3 v set, bit1 5 v set
  output logic      [1:0] below_falling,
  output logic      [1:0] above_rising
);
  assign below_falling = {lvl <= 3'h2, lvl == 3'h0};
  assign above_rising  = {lvl == 3'h4, lvl >= 3'h2};
endmodule // lvic_supply_model
`default_nettype wire

// file: tb/test_lvic_top.sv
// self-checking testbench of the supply monitor control
`timescale 1ns/1ps
`default_nettype none
`include "lvic_defines.svh"
module test_lvic_top;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        por_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        stop_mode = 1'b0;
  logic        wait_mode = 1'b0;
  logic [2:0]  lvl = 3'h2;
  logic [31:0] prdata, rd;
  logic [1:0]  below_falling, above_rising;
  logic        pready, pslverr, se, uv_reset_req, rst_pin_o, rst_pin_oe, trip_level_select;
  int          err_total = 0;
  int          checks = 0;

  always #12.5 clk = ~clk;

  lvic_supply_model i_sup (.lvl(lvl), .below_falling(below_falling), .above_rising(above_rising));

  lvic_top i_dut (
    .clk(clk), .arst_n(arst_n), .por_n(por_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .below_falling(below_falling), .above_rising(above_rising),
    .stop_mode(stop_mode), .wait_mode(wait_mode), .uv_reset_req(uv_reset_req),
    .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .trip_level_select(trip_level_select)
  );

  task cmp_reg(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task cmp_pin(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one apb transfer, entered and left just after a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task cfg(input logic [3:0] v);
    apb(1'b1, `LVIC_CONFIG_OFS, {28'h0, v});
  endtask

  // move the supply, let the synchroniser settle, check pins and flag
  task step(input logic [2:0] l, input logic r, input logic f);
    lvl <= l;
    repeat (5) @(posedge clk);
    @(negedge clk);
    cmp_pin(uv_reset_req, r);
    cmp_pin(rst_pin_oe, r);
    cmp_pin(rst_pin_o, 1'b0);
    @(posedge clk);
    apb(1'b0, `LVIC_STATUS_OFS, 32'h0);
    cmp_reg(rd, 32'(f) << `LVIC_FLAG_BIT);
  endtask

  task summarize;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    summarize;
  end

  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    por_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, `LVIC_CONFIG_OFS, 32'h0);
    cmp_reg(rd, 32'h0);
    cmp_pin(trip_level_select, 1'b0);
    step(3'h2, 1'b0, 1'b0);
    step(3'h0, 1'b1, 1'b1);
    step(3'h1, 1'b1, 1'b1);
    step(3'h2, 1'b0, 1'b0);
    cfg(4'h2);
    step(3'h0, 1'b0, 1'b1);
    step(3'h1, 1'b0, 1'b1);
    apb(1'b1, `LVIC_STATUS_OFS, 32'h0);
    step(3'h1, 1'b0, 1'b1);
    step(3'h2, 1'b0, 1'b0);
    cfg(4'h1);
    step(3'h0, 1'b0, 1'b0);
    stop_mode <= 1'b1;
    cfg(4'h0);
    step(3'h0, 1'b0, 1'b0);
    cfg(4'h4);
    step(3'h0, 1'b1, 1'b1);
    step(3'h2, 1'b0, 1'b0);
    stop_mode <= 1'b0;
    wait_mode <= 1'b1;
    step(3'h0, 1'b1, 1'b1);
    step(3'h2, 1'b0, 1'b0);
    wait_mode <= 1'b0;
    step(3'h3, 1'b0, 1'b0);
    cfg(4'h8);
    step(3'h3, 1'b1, 1'b0);
    cmp_pin(trip_level_select, 1'b1);
    step(3'h4, 1'b0, 1'b0);
    step(3'h2, 1'b1, 1'b1);
    arst_n <= 1'b0;
    step(3'h4, 1'b0, 1'b0);
    arst_n <= 1'b1;
    step(3'h4, 1'b0, 1'b0);
    por_n <= 1'b0;
    arst_n <= 1'b0;
    @(posedge clk);
    por_n <= 1'b1;
    arst_n <= 1'b1;
    @(posedge clk);
    cmp_pin(trip_level_select, 1'b0);
    apb(1'b0, 12'h008, 32'h0);
    cmp_reg(rd, 32'h0);
    cmp_pin(se, 1'b1);
    summarize;
  end
endmodule // test_lvic_top
`default_nettype wire
